// ---- ssa_consts.vh ----
`ifndef SSA_CONSTS_VH
`define SSA_CONSTS_VH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define SSA_OP_ERASE       8'h44
`define SSA_OP_PROGRAM     8'h42
`define SSA_OP_READ        8'h48

// ----------------------------------------------------------------
// frame bit positions (index of the rising edge, counted from 0)
// ----------------------------------------------------------------
`define SSA_BIT_OPCODE_END 6'h07
`define SSA_BIT_ADDR_END   6'h1f
`define SSA_BIT_DATA_START 6'h20
`define SSA_BIT_DATA_END   6'h27
`define SSA_BIT_READ_START 6'h28
`define SSA_BIT_READ_END   6'h2f

// ----------------------------------------------------------------
// area geometry
// ----------------------------------------------------------------
`define SSA_AREA_BYTES     1024
`define SSA_PAGE_BYTES     256
`define SSA_OFFSET_MAX     10'h3ff
`define SSA_ERASED_BYTE    8'hff

// ----------------------------------------------------------------
// timing: times in microseconds, clock in MHz
// ----------------------------------------------------------------
`define SSA_CLK_MHZ         200
`define SSA_AREA_ERASE_TIME_US 100000
`define SSA_PROG_TIME_US    1000

// ----------------------------------------------------------------
// busy sequencer states, one-hot
// ----------------------------------------------------------------
`define SSA_ST_IDLE        3'h1
`define SSA_ST_WALK        3'h2
`define SSA_ST_WAIT        3'h4

`endif

// ---- ssa_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module ssa_host (
  input  wire logic clk,
  input  wire logic so,
  input  wire logic oe,
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic si
);
  logic [7:0] wbuf [0:7];
  logic [7:0] rbuf [0:7];
  logic       oe_seen;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end
  // ----------------------------------------------------------------
  // one frame, mode 0, 32 clk per bit; nb whole bytes then xb loose bits
  // ----------------------------------------------------------------
  task automatic frame(input logic [7:0] op, input logic [23:0] ad, input int nb, input int xb);
    logic [31:0] hd;
    int          i;
    hd = {op, ad};
    oe_seen = 1'b0;
    @(negedge clk);
    cs_n = 1'b0;
    for (i = 0; i < 32 + 8 * nb + xb; i++) begin
      @(negedge clk);
      si = (i < 32) ? hd[31 - i] : wbuf[(i - 32) / 8][7 - i % 8];
      repeat (15) @(negedge clk);
      oe_seen = oe_seen | oe;
      // a released line must not pass for good data, so it reads inverted
      if (i >= 32) rbuf[(i - 32) / 8][7 - i % 8] = oe ? so : ~so;
      sclk = 1'b1;
      repeat (16) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (16) @(negedge clk);
    cs_n = 1'b1;
    si   = ~si; // no pull on this line, so never leave the last bit standing
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ---- ssa_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module ssa_monitor #(
  parameter ERASE_CYCLES = 2000,
  parameter PROG_CYCLES  = 400
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic serial_in_pin,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic write_enable_latch,
  input wire logic security_lock_bit,
  input wire logic quad_peripheral_mode,
  input wire logic other_cycle_busy,
  input wire logic write_in_progress_flag,
  input wire logic latch_clear
);
  int   busy_len_q;
  int   since_fall_q;
  logic sclk_q;
  // ----------------------------------------------------------------
  // helper counters; since_fall_q saturates at 99 and busy_len_q clears while idle, so a long idle cannot wrap them
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_len_q   <= 0;
      since_fall_q <= 0;
      sclk_q       <= 1'b0;
    end else begin
      busy_len_q   <= write_in_progress_flag ? busy_len_q + 1 : 0;
      since_fall_q <= (sclk_q && !spi_sclk) ? 0 : (since_fall_q < 99 ? since_fall_q + 1 : 99);
      sclk_q       <= spi_sclk;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  busy_length_a: assert property ($fell(write_in_progress_flag) |->
    (busy_len_q > PROG_CYCLES - 8 && busy_len_q < PROG_CYCLES + 8) ||
    (busy_len_q > ERASE_CYCLES - 8 && busy_len_q < ERASE_CYCLES + 8))
    else $error("busy time off");
  busy_start_a: assert property ($rose(write_in_progress_flag) |->
    spi_cs_n && !$past(spi_cs_n, 8)) else $error("busy not started by a frame end");
  latch_clear_end_a: assert property ($fell(write_in_progress_flag) |-> latch_clear)
    else $error("latch not cleared at end");
  latch_clear_only_a: assert property (latch_clear |-> $fell(write_in_progress_flag))
    else $error("stray latch clear");
  busy_needs_latch_a: assert property (
    $rose(write_in_progress_flag) |-> write_enable_latch)
    else $error("write started without latch");
  busy_locked_a: assert property ($rose(write_in_progress_flag) |-> !security_lock_bit)
    else $error("write started while locked");
  busy_quad_a: assert property ($rose(write_in_progress_flag) |-> !quad_peripheral_mode)
    else $error("write started in quad mode");
  read_idle_a: assert property ($rose(serial_out_oe) |->
    !write_in_progress_flag && !other_cycle_busy) else $error("read answered while busy");
  oe_release_a: assert property (spi_cs_n [*5] |-> !serial_out_oe)
    else $error("output kept after frame end");
  out_edge_a: assert property (
    serial_out_oe && $changed(serial_out) |-> since_fall_q <= 6)
    else $error("read bit moved away from falling clock");
endmodule
`default_nettype wire

// ---- ssa_sync.v ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// two-flop synchroniser, one per bit
// ----------------------------------------------------------------
module ssa_sync #(
  parameter WIDTH = 3
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      // only the second flop is visible outside
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
        end else begin
          meta_q <= async_in[g];
          sync_q <= meta_q;
        end
      end
      assign sync_out[g] = sync_q;
    end
  endgenerate

endmodule

`default_nettype wire

// ---- ssa_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ssa_consts.vh"
module security_sector_access_tb_top;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        wr_en = 1'b0;
  logic        lock = 1'b0;
  logic        quad = 1'b0;
  logic        obusy = 1'b0;
  logic [7:0]  seed = 8'h32;
  logic [3:0]  cf;
  logic [7:0]  op;
  logic [23:0] ad;
  logic [3:0]  nb;
  logic [3:0]  xb;
  logic [9:0]  off;
  wire         cs_n, sclk, si, so, oe, wr_busy, wclr;
  int          failures = 0;
  int          comparisons = 0;
  int          mem [0:1023];
  // row: latch lock quad busy, opcode, address, bytes, loose bits
  logic [43:0] refuse [0:8] = '{
    {4'h0, `SSA_OP_ERASE, 24'h0, 8'h00},
    {4'h0, `SSA_OP_PROGRAM, 24'h3fe, 8'h10},
    {4'hc, `SSA_OP_ERASE, 24'h0, 8'h00},
    {4'hc, `SSA_OP_PROGRAM, 24'h3fe, 8'h10},
    {4'ha, `SSA_OP_PROGRAM, 24'h3fe, 8'h10},
    {4'h8, `SSA_OP_ERASE, 24'h400, 8'h00},
    {4'h8, `SSA_OP_ERASE, 24'h0, 8'h04},
    {4'h9, `SSA_OP_READ, 24'h0, 8'h20},
    {4'ha, `SSA_OP_READ, 24'h0, 8'h20}};
  always #2.5 clk = ~clk;
  ssa_host u_host (.clk(clk), .so(so), .oe(oe), .cs_n(cs_n), .sclk(sclk), .si(si));
  ssa_top #(.ERASE_CYCLES(2000), .PROG_CYCLES(400)) dut (.clk(clk), .resetn(resetn),
    .spi_cs_n(cs_n), .spi_sclk(sclk), .serial_in_pin(si), .serial_out(so),
    .serial_out_oe(oe), .write_enable_latch(wr_en), .security_lock_bit(lock),
    .quad_peripheral_mode(quad), .other_cycle_busy(obusy),
    .write_in_progress_flag(wr_busy), .latch_clear(wclr));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("counts: %0d compares, %0d mismatches", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // busy must show, then end within a bounded wait
  // the outer latch is modelled here, so only this process drives wr_en
  task automatic settle;
    int n;
    repeat (20) @(negedge clk);
    chk(wr_busy, 1'b1);
    for (n = 0; n < 4000 && wr_busy !== 1'b0; n++) @(negedge clk);
    if (n == 4000) begin
      failures++;
      $display("ERROR t=%0t busy flag stuck got=%h exp=%h", $time, wr_busy, 1'b0);
      summarize();
    end
    chk(wclr, 1'b1);
    wr_en = 1'b0;
    @(negedge clk);
  endtask
  initial begin
    int i;
    int k;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (8) @(negedge clk);
    wr_en = 1'b1;
    u_host.frame(`SSA_OP_ERASE, 24'h0, 0, 0);
    u_host.frame(`SSA_OP_READ, 24'h0, 2, 0);
    chk(u_host.oe_seen, 1'b0);
    settle();
    chk(wclr, 1'b0);
    for (k = 0; k < 1024; k++) mem[k] = 255;
    $display("test erase done");
    for (k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      u_host.wbuf[k] = seed;
    end
    wr_en = 1'b1;
    u_host.frame(`SSA_OP_PROGRAM, 24'h3fe, 4, 0);
    for (k = 0; k < 4; k++) mem[768 + (254 + k) % 256] &= u_host.wbuf[k];
    settle();
    chk(wclr, 1'b0);
    $display("test program done");
    for (i = 0; i < 9; i++) begin
      {cf, op, ad, nb, xb} = refuse[i];
      {wr_en, lock, quad, obusy} = cf;
      for (k = 0; k < 8; k++) u_host.wbuf[k] = 8'h00;
      u_host.frame(op, ad, nb, xb);
      repeat (20) @(negedge clk);
      chk({wr_busy, u_host.oe_seen}, 2'b00);
      {wr_en, lock, quad, obusy} = 4'h0;
    end
    $display("test refusals done");
    for (i = 0; i < 2; i++) begin
      off = i ? 10'h300 : 10'h3fe;
      u_host.frame(`SSA_OP_READ, {14'h0, off}, 5, 0);
      for (k = 0; k < 4; k++) chk(u_host.rbuf[k + 1], mem[(off + k) % 1024]);
    end
    $display("test read back done");
    summarize();
  end
endmodule
bind ssa_top ssa_monitor #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) u_mon (
  .clk(clk), .resetn(resetn), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
  .serial_in_pin(serial_in_pin), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
  .write_enable_latch(write_enable_latch), .security_lock_bit(security_lock_bit),
  .quad_peripheral_mode(quad_peripheral_mode), .other_cycle_busy(other_cycle_busy),
  .write_in_progress_flag(write_in_progress_flag), .latch_clear(latch_clear));
`default_nettype wire

// ---- ssa_top.v ----
`timescale 1ns/10ps
`default_nettype none
`include "ssa_consts.vh"

module ssa_top #(
  parameter ERASE_CYCLES = `SSA_AREA_ERASE_TIME_US * `SSA_CLK_MHZ,
  parameter PROG_CYCLES  = `SSA_PROG_TIME_US * `SSA_CLK_MHZ
) (
  input  wire clk,
  input  wire resetn,
  input  wire spi_cs_n,
  input  wire spi_sclk,
  input  wire serial_in_pin,
  output wire serial_out,
  output wire serial_out_oe,
  input  wire write_enable_latch,
  input  wire security_lock_bit,
  input  wire quad_peripheral_mode,
  input  wire other_cycle_busy,
  output wire write_in_progress_flag,
  output wire latch_clear
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg  [1:0] rst_sync_q;
  wire       rst_n;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  wire [2:0] pins_s;
  wire       cs_n_s;
  wire       sclk_s;
  wire       si_s;
  reg        cs_n_d_q;
  reg        sclk_d_q;

  ssa_sync #(
    .WIDTH    (3)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({spi_cs_n, spi_sclk, serial_in_pin}),
    .sync_out (pins_s)
  );

  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign si_s   = pins_s[0];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_d_q <= 1'b1;
      sclk_d_q <= 1'b0;
    end else begin
      cs_n_d_q <= cs_n_s;
      sclk_d_q <= sclk_s;
    end
  end

  wire frame_on  = ~cs_n_s;
  wire cs_fall   = ~cs_n_s & cs_n_d_q;
  wire cs_rise   = cs_n_s & ~cs_n_d_q;
  wire sclk_rise = frame_on & sclk_s & ~sclk_d_q;
  wire sclk_fall = frame_on & ~sclk_s & sclk_d_q;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [7:0]   area_mem [0:`SSA_AREA_BYTES-1];
  reg [7:0]   page_buf [0:`SSA_PAGE_BYTES-1];
  reg [255:0] page_vld_q;

  // ----------------------------------------------------------------
  // frame decoder
  // ----------------------------------------------------------------
  reg  [5:0]  bit_cnt_q;
  reg  [23:0] shift_q;
  reg  [7:0]  opcode_q;
  reg         cmd_ok_q;
  reg         addr_ok_q;
  reg         overrun_q;
  reg  [9:0]  offset_q;
  reg  [7:0]  wr_ptr_q;
  reg         data_seen_q;
  reg  [1:0]  prog_page_q;
  reg  [7:0]  prog_start_q;
  reg  [2:0]  state_q;

  wire [23:0] shift_d   = {shift_q[22:0], si_s};
  wire        is_erase  = (opcode_q == `SSA_OP_ERASE);
  wire        is_prog   = (opcode_q == `SSA_OP_PROGRAM);
  wire        is_read   = (opcode_q == `SSA_OP_READ);
  wire        busy_any  = (state_q != `SSA_ST_IDLE) | other_cycle_busy;
  wire [7:0]  op_d      = shift_d[7:0];
  // spi mode only; read refused while anything is busy
  wire        op_ok_d   = ~quad_peripheral_mode & (
                            (op_d == `SSA_OP_ERASE) | (op_d == `SSA_OP_PROGRAM) |
                            ((op_d == `SSA_OP_READ) & ~busy_any));

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q   <= 6'h00;
      shift_q     <= 24'h000000;
      opcode_q    <= 8'h00;
      cmd_ok_q    <= 1'b0;
      addr_ok_q   <= 1'b0;
      overrun_q   <= 1'b0;
      offset_q    <= 10'h000;
      wr_ptr_q    <= 8'h00;
      data_seen_q <= 1'b0;
      page_vld_q  <= 256'h0;
    end else if (cs_fall) begin
      bit_cnt_q   <= 6'h00;
      opcode_q    <= 8'h00;
      cmd_ok_q    <= 1'b0;
      addr_ok_q   <= 1'b0;
      overrun_q   <= 1'b0;
      data_seen_q <= 1'b0;
      // buffer kept while a program commit may still be walking it
      if (state_q == `SSA_ST_IDLE) begin
        page_vld_q <= 256'h0;
      end
    end else if (sclk_rise) begin
      shift_q <= shift_d;
      if (bit_cnt_q == `SSA_BIT_OPCODE_END) begin
        opcode_q <= op_d;
        cmd_ok_q <= op_ok_d;
      end
      if (bit_cnt_q == `SSA_BIT_ADDR_END) begin
        addr_ok_q <= (shift_d[23:10] == 14'h0000);
        offset_q  <= shift_d[9:0];
        wr_ptr_q  <= shift_d[7:0];
      end
      if (bit_cnt_q >= `SSA_BIT_DATA_START) begin
        overrun_q <= 1'b1;
      end
      if (is_prog && cmd_ok_q && bit_cnt_q == `SSA_BIT_DATA_END &&
          state_q == `SSA_ST_IDLE) begin
        wr_ptr_q    <= wr_ptr_q + 8'h01; // wraps inside the page
        data_seen_q <= 1'b1;
        page_vld_q[wr_ptr_q] <= 1'b1;
      end
      // program data loops on bytes; read keeps counting dummy then data
      if (bit_cnt_q == `SSA_BIT_READ_END) begin
        bit_cnt_q <= `SSA_BIT_READ_START;
      end else if (bit_cnt_q == `SSA_BIT_DATA_END && !is_read) begin
        bit_cnt_q <= `SSA_BIT_DATA_START;
      end else begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
    end
  end

  always @(posedge clk) begin
    if (sclk_rise && is_prog && cmd_ok_q && bit_cnt_q == `SSA_BIT_DATA_END &&
        state_q == `SSA_ST_IDLE) begin
      page_buf[wr_ptr_q] <= shift_d[7:0];
    end
  end

  // ----------------------------------------------------------------
  // command acceptance at chip select rise
  // ----------------------------------------------------------------
  wire ready_wr = cmd_ok_q & addr_ok_q & (bit_cnt_q == `SSA_BIT_DATA_START) &
                  write_enable_latch & ~security_lock_bit &
                  ~quad_peripheral_mode & ~busy_any;
  wire start_erase = cs_rise & is_erase & ready_wr & ~overrun_q;
  // cs rising mid-byte leaves the counter off the boundary and is refused
  wire start_prog  = cs_rise & is_prog & ready_wr & data_seen_q;

  // ----------------------------------------------------------------
  // busy sequencer: walk the area (erase) or one page (program), then wait out the cycle time
  // ----------------------------------------------------------------
  reg  [2:0]  state_d;
  reg  [31:0] timer_q;
  reg  [9:0]  walk_q;
  reg         walk_erase_q;
  reg         latch_clr_q;
  wire        walk_last = walk_erase_q ? (walk_q == `SSA_OFFSET_MAX) :
                                         (walk_q[7:0] == 8'hff);

  always @* begin
    state_d = state_q;
    case (state_q)
      `SSA_ST_IDLE: begin
        if (start_erase || start_prog) begin
          state_d = `SSA_ST_WALK;
        end
      end
      `SSA_ST_WALK: begin
        if (walk_last) begin
          state_d = `SSA_ST_WAIT;
        end
      end
      `SSA_ST_WAIT: begin
        if (timer_q == 32'h0) begin
          state_d = `SSA_ST_IDLE;
        end
      end
      default: begin
        state_d = `SSA_ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= `SSA_ST_IDLE;
      timer_q      <= 32'h0;
      walk_q       <= 10'h000;
      walk_erase_q <= 1'b0;
      prog_page_q  <= 2'h0;
      prog_start_q <= 8'h00;
      latch_clr_q  <= 1'b0;
    end else begin
      state_q     <= state_d;
      latch_clr_q <= 1'b0;
      if (state_q == `SSA_ST_IDLE) begin
        walk_q <= 10'h000;
        if (start_erase) begin
          walk_erase_q <= 1'b1;
          timer_q      <= ERASE_CYCLES[31:0];
        end else if (start_prog) begin
          walk_erase_q <= 1'b0;
          timer_q      <= PROG_CYCLES[31:0];
          prog_page_q  <= offset_q[9:8];
          prog_start_q <= offset_q[7:0];
        end
      end else begin
        walk_q <= walk_q + 10'h001;
        if (timer_q != 32'h0) begin
          timer_q <= timer_q - 32'h1;
        end
        if (state_q == `SSA_ST_WAIT && timer_q == 32'h0) begin
          latch_clr_q <= 1'b1;
        end
      end
    end
  end

  // flash programming only pulls bits low, so data is anded in
  wire [7:0] prog_col = walk_q[7:0];
  wire [9:0] prog_adr = {prog_page_q, prog_col};

  always @(posedge clk) begin
    if (state_q == `SSA_ST_WALK) begin
      if (walk_erase_q) begin
        area_mem[walk_q] <= `SSA_ERASED_BYTE;
      end else if (page_vld_q[prog_col]) begin
        area_mem[prog_adr] <= area_mem[prog_adr] & page_buf[prog_col];
      end
    end
  end

  assign write_in_progress_flag = (state_q != `SSA_ST_IDLE);
  assign latch_clear            = latch_clr_q;

  // ----------------------------------------------------------------
  // read data path
  // ----------------------------------------------------------------
  reg [9:0] rd_ptr_q;
  reg [6:0] out_sr_q;
  reg       so_q;
  reg       so_en_q;
  wire      read_go = is_read & cmd_ok_q & (bit_cnt_q >= `SSA_BIT_READ_START);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_q <= 10'h000;
      out_sr_q <= 7'h00;
      so_q     <= 1'b0;
      so_en_q  <= 1'b0;
    end else if (!frame_on) begin
      so_en_q <= 1'b0;
    end else if (sclk_rise && bit_cnt_q == `SSA_BIT_ADDR_END) begin
      rd_ptr_q <= shift_d[9:0];
    end else if (sclk_fall && read_go) begin
      so_en_q <= 1'b1;
      if (bit_cnt_q[2:0] == 3'h0) begin
        so_q     <= area_mem[rd_ptr_q][7];
        out_sr_q <= area_mem[rd_ptr_q][6:0];
        rd_ptr_q <= rd_ptr_q + 10'h001;
      end else begin
        so_q     <= out_sr_q[6];
        out_sr_q <= {out_sr_q[5:0], 1'b0};
      end
    end
  end

  assign serial_out    = so_q;
  assign serial_out_oe = so_en_q & frame_on;

endmodule

`default_nettype wire
